// ---- src/cmpc_pkg.sv ----
// Constants and types for the comparator control block.
// Assumes a byte-wide special-function register port on the system clock.
package cmpc_pkg;
  localparam logic [7:0] CTRL_ADDR      = 8'h9B;
  localparam logic [7:0] INSEL_ADDR     = 8'h9F;
  localparam logic [7:0] MODE_ADDR      = 8'h9D;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] INSEL_RESET    = 8'hFF;
  localparam logic [7:0] MODE_RESET     = 8'h02;
  localparam int         BIT_ON         = 7;
  localparam int         BIT_RESULT     = 6;
  localparam int         BIT_RISE       = 5;
  localparam int         BIT_FALL       = 4;
  localparam int         POS_HI         = 3;
  localparam int         POS_LO         = 2;
  localparam int         NEG_HI         = 1;
  localparam int         NEG_LO         = 0;
  localparam int         SEL_W          = 4;
  localparam int         MODE_W         = 2;

  typedef struct packed {
    logic [SEL_W-1:0] negative_input_sel;
    logic [SEL_W-1:0] positive_input_sel;
  } cmpc_insel_type;

  typedef struct packed {
    logic             comparator_on;
    logic [1:0]       pos_hysteresis_sel;
    logic [1:0]       neg_hysteresis_sel;
    logic [MODE_W-1:0] response_mode;
    cmpc_insel_type   insel;
  } cmpc_analog_cfg_type;
endpackage

// ---- src/cmpc_sync.sv ----
// Three-stage synchroniser with agreement filter for the comparator output.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module cmpc_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  import cmpc_pkg::*;
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic out_ff;
  wire  agree = (s2_ff == s3_ff);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      out_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (agree)
        out_ff <= s3_ff;
    end
  end

  assign dout = out_ff;
endmodule // cmpc_sync

// ---- src/cmpc_ctrl.sv ----
// Control and status logic around an analog voltage comparator.
// Assumes a byte SFR port (address, write strobe, read data) on MCLK.
// Operation
// - Enable bit turns comparator on/off
// - Current result readable as status bit
// - Rising transition sets rise flag
// - Falling transition sets fall flag
// - Flags stay set until software clears
// - Rise flag interrupts only when enabled
// - Fall flag interrupts only when enabled
// - Disabled comparator drives pin outputs low
// - Offer latched and raw outputs
// - Raw output needs no clock
// - Bits 3-2 select positive hysteresis
// - Bits 1-0 select negative hysteresis
// - Input-select register picks input pins
// - Mode register selects response time
// - Output offered as reset source
`timescale 1ns/100ps
module cmpc_ctrl
(
  input  wire logic                          MCLK,
  input  wire logic                          RST,
  input  wire logic [7:0]                    SFR_ADDR,
  input  wire logic                          SFR_WR,
  input  wire logic [7:0]                    SFR_WDATA,
  output logic      [7:0]                    SFR_RDATA,
  input  wire logic                          CMP_ANALOG_OUT,
  input  wire logic                          RESET_SRC_EN,
  output cmpc_pkg::cmpc_analog_cfg_type      ANALOG_CFG,
  output logic                               LATCHED_CMP_OUTPUT,
  output logic                               RAW_CMP_OUTPUT,
  output logic                               CMP_IRQ,
  output logic                               CMP_RESET_REQ
);
  import cmpc_pkg::*;

  logic                ctrl_on_ff;
  logic                rise_seen_flag_ff;
  logic                fall_seen_flag_ff;
  logic                rise_irq_enable_ff;
  logic                fall_irq_enable_ff;
  logic [1:0]          pos_hyst_ff;
  logic [1:0]          neg_hyst_ff;
  logic [MODE_W-1:0]   mode_ff;
  cmpc_insel_type      insel_ff;
  logic                prev_ff;
  logic                latched_ff;
  logic                irq_ff;
  logic                rst_req_ff;
  logic [7:0]          rdata_ff;
  cmpc_analog_cfg_type cfg_ff;
  logic                sync_out;

  // raw path is combinational gate on analog output; no clock involved
  // Raw path gated off while disabled; needs no clock
  assign RAW_CMP_OUTPUT = CMP_ANALOG_OUT & ctrl_on_ff;

  cmpc_sync u_sync
  (
    .clk  (MCLK),
    .rst  (RST),
    .din  (CMP_ANALOG_OUT),
    .dout (sync_out)
  );

  wire wr_ctrl  = SFR_WR && (SFR_ADDR == CTRL_ADDR);
  wire wr_insel = SFR_WR && (SFR_ADDR == INSEL_ADDR);
  wire wr_mode  = SFR_WR && (SFR_ADDR == MODE_ADDR);
  wire result   = sync_out & ctrl_on_ff;
  wire rise_ev  = result & ~prev_ff;
  wire fall_ev  = ~result & prev_ff;

  // Set wins over a same-cycle software clear
  wire nxt_rise_flag = rise_ev | (wr_ctrl ? SFR_WDATA[BIT_RISE] : rise_seen_flag_ff);
  wire nxt_fall_flag = fall_ev | (wr_ctrl ? SFR_WDATA[BIT_FALL] : fall_seen_flag_ff);
  wire nxt_irq = (nxt_rise_flag & rise_irq_enable_ff) |
                 (nxt_fall_flag & fall_irq_enable_ff);

  wire [7:0] ctrl_view = {ctrl_on_ff, result, rise_seen_flag_ff, fall_seen_flag_ff,
                          pos_hyst_ff, neg_hyst_ff};
  // Mode byte shows the response mode and both interrupt enables
  logic [7:0] mode_view;
  always_comb
  begin
    mode_view               = 8'h00;
    mode_view[MODE_W-1:0]   = mode_ff;
    mode_view[BIT_RISE]     = rise_irq_enable_ff;
    mode_view[BIT_FALL]     = fall_irq_enable_ff;
  end

  wire [7:0] nxt_rdata = (SFR_ADDR == CTRL_ADDR)  ? ctrl_view :
                         (SFR_ADDR == INSEL_ADDR) ? insel_ff :
                         (SFR_ADDR == MODE_ADDR)  ? mode_view : 8'h00;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ctrl_on_ff        <= CTRL_RESET[BIT_ON];
      pos_hyst_ff       <= CTRL_RESET[POS_HI:POS_LO];
      neg_hyst_ff       <= CTRL_RESET[NEG_HI:NEG_LO];
      rise_seen_flag_ff <= 1'b0;
      fall_seen_flag_ff <= 1'b0;
      insel_ff          <= INSEL_RESET;
      mode_ff           <= MODE_RESET[MODE_W-1:0];
    end
    else
    begin
      rise_seen_flag_ff <= nxt_rise_flag;
      fall_seen_flag_ff <= nxt_fall_flag;
      if (wr_ctrl)
      begin
        ctrl_on_ff  <= SFR_WDATA[BIT_ON];
        pos_hyst_ff <= SFR_WDATA[POS_HI:POS_LO];
        neg_hyst_ff <= SFR_WDATA[NEG_HI:NEG_LO];
      end
      if (wr_insel)
        insel_ff <= SFR_WDATA;
      if (wr_mode)
        mode_ff <= SFR_WDATA[MODE_W-1:0];
    end
  end

  // Interrupt enables kept apart from the control byte, in mode register bits 5 and 4
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rise_irq_enable_ff <= 1'b0;
      fall_irq_enable_ff <= 1'b0;
    end
    else if (wr_mode)
    begin
      rise_irq_enable_ff <= SFR_WDATA[BIT_RISE];
      fall_irq_enable_ff <= SFR_WDATA[BIT_FALL];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      prev_ff    <= 1'b0;
      latched_ff <= 1'b0;
      irq_ff     <= 1'b0;
      rst_req_ff <= 1'b0;
      rdata_ff   <= 8'h00;
      cfg_ff     <= '0;
    end
    else
    begin
      prev_ff    <= result;
      latched_ff <= result;
      irq_ff     <= nxt_irq;
      rst_req_ff <= result & RESET_SRC_EN;
      rdata_ff   <= nxt_rdata;
      cfg_ff     <= '{ctrl_on_ff, pos_hyst_ff, neg_hyst_ff, mode_ff, insel_ff};
    end
  end

  assign LATCHED_CMP_OUTPUT = latched_ff;
  assign CMP_IRQ            = irq_ff;
  assign CMP_RESET_REQ      = rst_req_ff;
  assign SFR_RDATA          = rdata_ff;
  assign ANALOG_CFG         = cfg_ff;

  // is the software's duty; flags are plain sticky bits.

  rise_sticky_a: assert property (@(posedge MCLK) disable iff (RST)
    rise_seen_flag_ff && !(wr_ctrl && !SFR_WDATA[BIT_RISE]) |=> rise_seen_flag_ff)
    else $error("rise flag dropped without clear");
  fall_sticky_a: assert property (@(posedge MCLK) disable iff (RST)
    fall_seen_flag_ff && !(wr_ctrl && !SFR_WDATA[BIT_FALL]) |=> fall_seen_flag_ff)
    else $error("fall flag dropped without clear");
  rise_set_a: assert property (@(posedge MCLK) disable iff (RST)
    $rose(result) |=> rise_seen_flag_ff)
    else $error("rise flag not set on edge");
  fall_set_a: assert property (@(posedge MCLK) disable iff (RST)
    $fell(result) |=> fall_seen_flag_ff)
    else $error("fall flag not set on edge");
  irq_gate_a: assert property (@(posedge MCLK) disable iff (RST)
    CMP_IRQ |-> $past(nxt_irq))
    else $error("irq without enabled flag");
  irq_fall_a: assert property (@(posedge MCLK) disable iff (RST)
    fall_seen_flag_ff && fall_irq_enable_ff && !(wr_ctrl && !SFR_WDATA[BIT_FALL])
    |=> CMP_IRQ)
    else $error("fall irq missing");
  off_low_a: assert property (@(posedge MCLK) disable iff (RST)
    !ctrl_on_ff [*2] |-> !LATCHED_CMP_OUTPUT && !RAW_CMP_OUTPUT)
    else $error("output high while disabled");
  enable_write_a: assert property (@(posedge MCLK) disable iff (RST)
    wr_ctrl |=> ctrl_on_ff == $past(SFR_WDATA[BIT_ON]))
    else $error("enable bit not written");
  hyst_write_a: assert property (@(posedge MCLK) disable iff (RST)
    wr_ctrl |=> ##1 ANALOG_CFG.neg_hysteresis_sel == $past(SFR_WDATA[NEG_HI:NEG_LO], 2))
    else $error("hysteresis not passed");
endmodule // cmpc_ctrl

// ---- test/cmpc_analog_model.sv ----
// Behavioural analog comparator core for the control block bench.
// Assumes the bench sets the input difference as a plain logic level.
`timescale 1ns/100ps
module cmpc_analog_model
(
  input  wire cmpc_pkg::cmpc_analog_cfg_type cfg,
  input  wire logic                          level,
  output logic                               cmp_out
);
  import cmpc_pkg::*;
  // Slower response modes answer later; powered-off core sits low
  always @(cfg or level)
    cmp_out <= #((cfg.response_mode + 1) * 10) (cfg.comparator_on & level);
endmodule // cmpc_analog_model

// ---- test/tb_cmpc_ctrl.sv ----
// Self-checking bench for the comparator control block.
// Assumes the analog core model and the design package are compiled first.
`timescale 1ns/100ps
module tb_cmpc_ctrl;
  import cmpc_pkg::*;
  logic                MCLK = 0, RST = 1, SFR_WR = 0, RESET_SRC_EN = 0, level = 0;
  logic [7:0]          SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, rd_val;
  logic                CMP_ANALOG_OUT, LATCHED_CMP_OUTPUT, RAW_CMP_OUTPUT;
  logic                CMP_IRQ, CMP_RESET_REQ;
  cmpc_analog_cfg_type ANALOG_CFG;
  int                  errors = 0, tests_run = 0;
  // Address, write data, expected read-back
  logic [23:0]         rows [5] = '{24'h9B4F0F, 24'h9B0D0D, 24'h9F5A5A, 24'h9D3131,
                                    24'hA05500};
  always #12.5 MCLK = ~MCLK;
  cmpc_ctrl u_cmpc_ctrl (.MCLK(MCLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CMP_ANALOG_OUT(CMP_ANALOG_OUT),
    .RESET_SRC_EN(RESET_SRC_EN), .ANALOG_CFG(ANALOG_CFG),
    .LATCHED_CMP_OUTPUT(LATCHED_CMP_OUTPUT), .RAW_CMP_OUTPUT(RAW_CMP_OUTPUT),
    .CMP_IRQ(CMP_IRQ), .CMP_RESET_REQ(CMP_RESET_REQ));
  cmpc_analog_model u_cmpc_analog_model (.cfg(ANALOG_CFG), .level(level),
    .cmp_out(CMP_ANALOG_OUT));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge MCLK);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    @(negedge MCLK);
    SFR_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge MCLK);
    SFR_ADDR = a;
    @(negedge MCLK);
    rd_val = SFR_RDATA;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (12) @(negedge MCLK);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge MCLK);
    errors++;
    $display("[ERR] %0t run did not complete", $time);
    final_report();
  end
  initial
  begin
    repeat (10) @(negedge MCLK);
    RST = 1'b0;
    rd(CTRL_ADDR);
    chk8(rd_val, CTRL_RESET);
    rd(INSEL_ADDR);
    chk8(rd_val, INSEL_RESET);
    rd(MODE_ADDR);
    chk8(rd_val, MODE_RESET);
    chk1(CMP_IRQ, 1'b0);
    $display("reset test done");
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk8(rd_val, rows[i][7:0]);
    end
    chk8({1'b0, ANALOG_CFG[14:8]}, 8'h35);
    chk8(ANALOG_CFG.insel, 8'h5A);
    $display("register table test done");
    wr(CTRL_ADDR, 8'h80);
    wr(MODE_ADDR, 8'h30);
    settle();
    wr(CTRL_ADDR, 8'h80);
    level = 1'b1;
    settle();
    rd(CTRL_ADDR);
    chk8(rd_val, 8'hE0);
    chk1(CMP_IRQ, 1'b1);
    chk1(LATCHED_CMP_OUTPUT, 1'b1);
    chk1(RAW_CMP_OUTPUT, 1'b1);
    wr(CTRL_ADDR, 8'h80);
    settle();
    rd(CTRL_ADDR);
    chk8(rd_val, 8'hC0);
    chk1(CMP_IRQ, 1'b0);
    level = 1'b0;
    settle();
    rd(CTRL_ADDR);
    chk8(rd_val, 8'h90);
    chk1(CMP_IRQ, 1'b1);
    wr(MODE_ADDR, 8'h20);
    settle();
    chk1(CMP_IRQ, 1'b0);
    rd(CTRL_ADDR);
    chk8(rd_val, 8'h90);
    $display("edge flag test done");
    RESET_SRC_EN = 1'b1;
    level = 1'b1;
    settle();
    chk1(CMP_RESET_REQ, 1'b1);
    wr(CTRL_ADDR, 8'h00);
    settle();
    chk1(LATCHED_CMP_OUTPUT, 1'b0);
    chk1(RAW_CMP_OUTPUT, 1'b0);
    chk1(CMP_RESET_REQ, 1'b0);
    $display("disable test done");
    final_report();
  end
endmodule // tb_cmpc_ctrl
